// [tb/mnr_exec_checker.sv]
// Port-level assertions for the instruction executor, bound to every instance
`timescale 1ns/1ps
module mnr_exec_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction feed
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_done,
  // Data file and core registers
  input wire logic [7:0] file_rdata,
  input wire mnr_pkg::mnr_file_wr_t file_wr,
  input wire logic [7:0] working_register,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte,
  input wire mnr_pkg::mnr_flags_t alu_flags,
  input wire logic [7:0] cpu_status_register,
  input wire logic glint_set,
  // Program counter and stack
  input wire logic [15:0] pc,
  input wire logic stack_push,
  input wire logic [15:0] top_of_stack_entry,
  input wire logic [3:0] stack_ptr
);
  import mnr_pkg::*;
  logic [15:0] tw;
  logic [7:0] w_q, rd_q, neg_w;
  logic [3:0] cnt;
  logic op_mul, op_neg, op_rfi, op_rlw, op_nop, op_ret;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Clocks since the take edge; saturates so a long idle spell never aliases a phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else if (instr_ready && instr_valid) begin
      cnt <= 4'h1;
    end else if (cnt != 4'h0 && cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end

  // Operands as the executor should see them: word and W at take, file byte at Q2
  always_ff @(posedge ref_clk) begin
    if (instr_ready && instr_valid) begin
      tw <= instr_word;
      w_q <= working_register;
    end
    if (cnt == 4'h1) begin
      rd_q <= file_rdata;
    end
  end

  // Decode of the word in flight
  assign op_mul = tw[15:8] == OPC_MUL_FILE_HI;
  assign op_neg = tw[15:9] == OPC_NEG_W_HI;
  assign op_rfi = tw == OPC_RET_INT;
  assign op_rlw = tw[15:8] == OPC_RET_LIT_HI;
  assign op_nop = tw == OPC_NOP;
  assign op_ret = op_rfi || op_rlw;
  assign neg_w = ~w_q + 8'h01;

  // Bit set through Q3, gone right after the Q3 edge
  sequence s_clear;
    cpu_status_register[GLINT_BIT] ##1 !cpu_status_register[GLINT_BIT];
  endsequence
  // Idle second cycle: no new word and no completion until its own Q4 has passed
  sequence s_flush;
    (!instr_ready && !instr_done) [*4] ##1 instr_done;
  endsequence

  a_mul_product: assert property (cnt == 4'h4 && op_mul |->
    {product_high_byte, product_low_byte} == 16'(w_q) * 16'(rd_q)
    && working_register == w_q && alu_flags == $past(alu_flags, 4)) else $error("mul wrong");
  a_write_source: assert property (file_wr.we |-> cnt == 4'h4 && op_neg)
    else $error("stray file write");
  a_negate_result: assert property (cnt == 4'h4 && op_neg |-> file_wr.we
    && file_wr.addr == tw[7:0] && file_wr.data == neg_w
    && working_register == (tw[NEG_SEL_BIT] ? w_q : neg_w)) else $error("negate wrong");
  a_negate_flags: assert property (cnt == 4'h4 && op_neg |-> alu_flags ==
    {w_q == 8'h80, neg_w == 8'h00, w_q[3:0] == 4'h0, w_q == 8'h00}) else $error("flags wrong");
  a_disable_clear: assert property (cnt == 4'h2 && op_rfi && !glint_set
    && $past(cpu_status_register, 2) == 8'h10 |-> s_clear) else $error("disable bit timing");
  a_return_pop: assert property (cnt == 4'h3 && op_ret && !stack_push |=>
    pc == $past(top_of_stack_entry) && stack_ptr == $past(stack_ptr) - 4'h1)
    else $error("return pop wrong");
  a_return_flush: assert property (cnt == 4'h4 && op_ret |-> s_flush)
    else $error("return not two cycles");
  a_literal_load: assert property (cnt == 4'h4 && op_rlw |->
    working_register == tw[7:0] && alu_flags == $past(alu_flags, 4)) else $error("literal wrong");
  a_nop_step: assert property (cnt == 4'h4 && op_nop |-> pc == $past(pc, 4) + PC_STEP
    && working_register == w_q && alu_flags == $past(alu_flags, 4)) else $error("nop wrong");
endmodule : mnr_exec_checker

bind mnr_exec mnr_exec_checker i_chk (
  .ref_clk, .rst_n, .instr_valid, .instr_word, .instr_ready, .instr_done, .file_rdata, .file_wr,
  .working_register, .product_high_byte, .product_low_byte, .alu_flags, .cpu_status_register,
  .glint_set, .pc, .stack_push, .top_of_stack_entry, .stack_ptr
);

// [tb/tb.sv]
// Directed bench for the executor: returns, negate, multiply and no-operation
`timescale 1ns/1ps
module tb;
  import mnr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic glint_set = 1'b0;
  logic pc_high_latch_load = 1'b0;
  logic [7:0] pc_high_latch_wdata = 8'h5A;
  logic stack_push = 1'b0;
  logic [15:0] stack_push_addr = 16'h0000;
  logic instr_ready, instr_done, unknown_op;
  logic [7:0] file_addr, working_register, product_high_byte, product_low_byte;
  logic [7:0] cpu_status_register, pc_high_latch, w, nw;
  logic [15:0] pc, top_of_stack_entry, ra;
  logic [3:0] stack_ptr;
  mnr_file_wr_t file_wr, wr_last;
  mnr_flags_t alu_flags, fl;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int wr_seen = 0;
  int wr_base;
  // Rows: working value, select bit, file byte for the multiply
  logic [7:0] w_tab [4] = '{8'h3A, 8'h00, 8'h80, 8'hF0};
  logic s_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] rd_tab [4] = '{8'hB5, 8'h5A, 8'hFF, 8'h00};

  mnr_exec i_dut (
    .ref_clk, .rst_n, .clk_en, .instr_valid, .instr_word, .instr_ready, .instr_done,
    .unknown_op, .file_addr, .file_rdata, .file_wr, .working_register, .product_high_byte,
    .product_low_byte, .alu_flags, .cpu_status_register, .glint_set, .pc, .pc_high_latch,
    .pc_high_latch_load, .pc_high_latch_wdata, .stack_push, .stack_push_addr, .top_of_stack_entry, .stack_ptr
  );

  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // Record file writes mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (file_wr.we === 1'b1) begin
      wr_seen++;
      wr_last = file_wr;
    end
  end

  // Hang guard; the whole run needs well under a thousand clocks
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Offer one word, hold it until taken, then wait for completion
  task automatic exec(input logic [15:0] word, input logic [7:0] rdata);
    int n;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b1;
    instr_word = word;
    file_rdata = rdata;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    instr_word = ~word;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_done !== 1'b1 && n < 40);
    check(16'(instr_done), 16'h0001, "completion");
    // Let the negedge write recorder run before the caller compares
    #1;
  endtask : exec

  // Push a return address; the address lines are scrambled after release
  task automatic push(input logic [15:0] addr);
    @(posedge ref_clk);
    #1;
    stack_push = 1'b1;
    stack_push_addr = addr;
    @(posedge ref_clk);
    #1;
    stack_push = 1'b0;
    stack_push_addr = ~addr;
  endtask : push

  // Load W by a literal return; the only instruction in this block that loads W with a chosen value
  task automatic load_w(input logic [7:0] val, input logic [15:0] addr);
    push(addr);
    fl = alu_flags;
    exec({OPC_RET_LIT_HI, val}, 8'h00);
    check(working_register, val, "literal");
    check(pc, addr, "return pc");
    check(stack_ptr, 4'h0, "depth");
    check(pc_high_latch, 8'h5A, "latch");
    check(alu_flags, fl, "literal flags");
  endtask : load_w

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    pc_high_latch_load = 1'b1;
    @(posedge ref_clk);
    #1;
    pc_high_latch_load = 1'b0;
    exec(OPC_NOP, 8'h00);
    check(pc, 16'h0001, "nop pc");
    check(working_register, 8'h00, "nop w");
    check(unknown_op, 1'b0, "nop decoded");
    $display("test nop done");
    exec(16'hFFFF, 8'h00);
    check(unknown_op, 1'b1, "unknown op");
    check(pc, 16'h0002, "unknown pc");
    check(working_register, 8'h00, "unknown w");
    $display("test unknown op done");
    push(16'h0A50);
    exec(OPC_RET_INT, 8'h00);
    check(pc, 16'h0A50, "return_from_interrupt_op pc");
    check(cpu_status_register, 8'h00, "disable bit");
    check(pc_high_latch, 8'h5A, "latch");
    $display("test interrupt return done");
    // Each row: negate a loaded W, then multiply the outcome
    for (int i = 0; i < 4; i++) begin
      ra = 16'h0100 + 16'(i);
      load_w(w_tab[i], ra);
      w = w_tab[i];
      nw = ~w + 8'h01;
      wr_base = wr_seen;
      exec({OPC_NEG_W_HI, s_tab[i], 8'(32 + i)}, 8'hAB);
      check(working_register, s_tab[i] ? w : nw, "negate w");
      check(alu_flags, {w == 8'h80, nw == 8'h00, w[3:0] == 4'h0, w == 8'h00}, "flags");
      check(wr_last.addr, 8'(32 + i), "write addr");
      check(wr_last.data, nw, "write data");
      w = s_tab[i] ? w : nw;
      fl = alu_flags;
      exec({OPC_MUL_FILE_HI, 8'h40}, rd_tab[i]);
      check(file_addr, 8'h40, "file addr");
      check({product_high_byte, product_low_byte}, 16'(w) * 16'(rd_tab[i]), "product");
      check(working_register, w, "mul w");
      check(16'(wr_seen - wr_base), 16'h0001, "writes");
      check(alu_flags, fl, "mul flags");
      check(pc, ra + 16'h0002, "pc step");
      $display("test row %0d done", i);
    end
    final_report();
  end
endmodule : tb

// [verilog/mnr_exec.sv]
// Executor for multiply, negate, no-operation and the two return instructions
// Timing of one instruction cycle, one phase per enabled clock:
//   Q1  take the offered word, or insert a bubble when none is offered
//   Q2  read the addressed file byte into the operand register
//   Q3  clear the interrupt disable bit of an interrupt return
//   Q4  write results, step or reload the PC, pop the return stack
// The two returns then spend a whole idle cycle with no word taken, which
// gives the fetch side time to refill from the popped address.
// clk_en gates every register here and in both submodules, so a low enable
// stretches the current phase without losing or repeating any step.
// A bubble leaves W, the flags, the product pair and the PC alone, so a stalled fetch
// never skips an address.
// Limitation: the stack has no overflow trap; a seventeenth push silently
// overwrites the oldest entry.
`timescale 1ns/1ps
module mnr_exec (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Instruction feed
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  output logic unknown_op,
  // Data file access
  output logic [7:0] file_addr,
  input wire logic [7:0] file_rdata,
  output mnr_pkg::mnr_file_wr_t file_wr,
  // Core registers
  output logic [7:0] working_register,
  output logic [7:0] product_high_byte,
  output logic [7:0] product_low_byte,
  output mnr_pkg::mnr_flags_t alu_flags,
  output logic [7:0] cpu_status_register,
  input wire logic glint_set,
  // Program counter and its high latch
  output logic [15:0] pc,
  output logic [7:0] pc_high_latch,
  input wire logic pc_high_latch_load,
  input wire logic [7:0] pc_high_latch_wdata,
  // Return stack push from call or interrupt logic
  input wire logic stack_push,
  input wire logic [15:0] stack_push_addr,
  output logic [15:0] top_of_stack_entry,
  output logic [3:0] stack_ptr
);
  import mnr_pkg::*;

  // Sequencing
  mnr_phase_t phase;
  mnr_state_t state;
  mnr_state_t next_state;
  mnr_op_t op;
  logic [15:0] ir;
  logic ir_valid;
  logic first_cycle;
  logic is_return;
  logic do_pop;
  logic last_q4;

  // Datapath
  logic [7:0] operand;
  logic global_interrupt_disable;
  logic [15:0] product;
  logic [8:0] neg_sum;
  logic [4:0] neg_low;
  logic [7:0] neg_result;
  mnr_flags_t neg_flags;

  // Classify the latched instruction word
  function automatic mnr_op_t decode_op(input logic [15:0] w);
    mnr_op_t r;
    r = MNR_OP_OTHER;
    if (w == OPC_NOP) begin
      r = MNR_OP_NOP;
    end else if (w == OPC_RET_INT) begin
      r = MNR_OP_RET_INT;
    end else if (w[15:8] == OPC_MUL_FILE_HI) begin
      r = MNR_OP_MUL;
    end else if (w[15:9] == OPC_NEG_W_HI) begin
      r = MNR_OP_NEG;
    end else if (w[15:8] == OPC_RET_LIT_HI) begin
      r = MNR_OP_RET_LIT;
    end
    return r;
  endfunction : decode_op

  mnr_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .phase(phase)
  );

  mnr_ret_stack u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .push(stack_push),
    .push_addr(stack_push_addr),
    .pop(do_pop),
    .top_of_stack_entry(top_of_stack_entry),
    .stack_ptr(stack_ptr)
  );

  assign op = ir_valid ? decode_op(ir) : MNR_OP_NOP;

  // A word is taken only at Q1 of a first cycle; the idle second cycle refuses it
  assign instr_ready = clk_en && (phase == MNR_Q1) && (state == MNR_ST_RUN);

  // First cycle of a real word; the idle second cycle and bubbles are excluded
  assign first_cycle = ir_valid && (state == MNR_ST_RUN);

  // Either return instruction; both share the pop and the idle second cycle
  assign is_return = (op == MNR_OP_RET_INT) || (op == MNR_OP_RET_LIT);

  // Both return instructions pop in Q4 of their first cycle
  assign do_pop = first_cycle && (phase == MNR_Q4) && is_return;

  assign last_q4 = clk_en && (phase == MNR_Q4);

  // Unsigned 8 x 8 multiply, no flag output by construction
  assign product = 16'(working_register) * 16'(operand);

  // Two's complement: inverted value plus one; the digit carry comes from a separate low-nibble adder
  assign neg_sum = {1'b0, ~working_register} + NEG_ONE9;
  assign neg_low = {1'b0, ~working_register[3:0]} + NEG_ONE5;
  assign neg_result = neg_sum[7:0];

  // Flags of the negation; only 0x80 overflows in signed terms
  always_comb begin
    neg_flags.carry = neg_sum[8];
    neg_flags.digit_carry_flag = neg_low[4];
    neg_flags.zero = (neg_result == 8'h00);
    neg_flags.overflow_flag = (working_register == BYTE_MIN_NEG);
  end

  // Run / flush sequencing of one- and two-cycle instructions
  always_comb begin
    next_state = state;
    unique case (state)
      MNR_ST_RUN: begin
        if (ir_valid && is_return) begin
          next_state = MNR_ST_FLUSH;
        end
      end
      MNR_ST_FLUSH: begin
        next_state = MNR_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MNR_ST_RUN;
    end else if (last_q4) begin
      state <= next_state;
    end
  end

  // Q1 decode: latch the word, or a bubble when none is offered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir <= IR_RST;
      ir_valid <= 1'b0;
    end else if (clk_en && (phase == MNR_Q1)) begin
      if (state == MNR_ST_RUN) begin
        ir <= instr_word;
        ir_valid <= instr_valid;
      end else begin
        ir_valid <= 1'b0;
      end
    end
  end

  // Q2 read: the file address is the low byte of the word
  assign file_addr = ir[7:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand <= 8'h00;
    end else if (clk_en && (phase == MNR_Q2) && ir_valid) begin
      operand <= file_rdata;
    end
  end

  // Q4 working register: negate with select 0, or the return literal
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      working_register <= W_RST;
    end else if (last_q4 && first_cycle) begin
      if ((op == MNR_OP_NEG) && !ir[NEG_SEL_BIT]) begin
        working_register <= neg_result;
      end else if (op == MNR_OP_RET_LIT) begin
        working_register <= ir[7:0];
      end
    end
  end

  // Q4 product pair, high byte in the upper register; multiply touches nothing else
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      product_high_byte <= PROD_RST;
      product_low_byte <= PROD_RST;
    end else if (last_q4 && ir_valid && (op == MNR_OP_MUL)) begin
      product_high_byte <= product[15:8];
      product_low_byte <= product[7:0];
    end
  end

  // Q4 file write: negate always writes the file; a one-cycle strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_wr <= FILE_WR_RST;
    end else if (clk_en) begin
      file_wr.we <= (phase == MNR_Q4) && ir_valid && (op == MNR_OP_NEG);
      file_wr.addr <= ir[7:0];
      file_wr.data <= neg_result;
    end
  end

  // Status flags change only on negate; return literal and multiply leave them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags <= FLAGS_RST;
    end else if (last_q4 && ir_valid && (op == MNR_OP_NEG)) begin
      alu_flags <= neg_flags;
    end
  end

  // Interrupt disable: cleared at Q3 of interrupt return; a set in that cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_interrupt_disable <= GLINT_RST;
    end else if (clk_en) begin
      if (glint_set) begin
        global_interrupt_disable <= 1'b1;
      end else if ((phase == MNR_Q3) && first_cycle && (op == MNR_OP_RET_INT)) begin
        global_interrupt_disable <= 1'b0;
      end
    end
  end

  // Only the disable bit is held here; the other status bits read as zero
  always_comb begin
    cpu_status_register = 8'h00;
    cpu_status_register[GLINT_BIT] = global_interrupt_disable;
  end

  // Program counter: popped entry on returns, otherwise step after a real word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RST;
    end else if (last_q4 && ir_valid && (state == MNR_ST_RUN)) begin
      if (do_pop) begin
        pc <= top_of_stack_entry;
      end else begin
        pc <= pc + PC_STEP;
      end
    end
  end

  // High latch changes only by its own load port, never by a return
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_latch <= LATCH_RST;
    end else if (clk_en && pc_high_latch_load) begin
      pc_high_latch <= pc_high_latch_wdata;
    end
  end

  // Completion strobe at the final Q4 of an instruction; a bubble completes nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_done <= 1'b0;
    end else if (clk_en) begin
      instr_done <= (phase == MNR_Q4) &&
                    ((state == MNR_ST_FLUSH) || (ir_valid && (next_state == MNR_ST_RUN)));
    end
  end

  // Unknown-op strobe beside it; the word still steps the PC so fetch never stalls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unknown_op <= 1'b0;
    end else if (clk_en) begin
      unknown_op <= (phase == MNR_Q4) && first_cycle && (op == MNR_OP_OTHER);
    end
  end

endmodule : mnr_exec

// [verilog/mnr_phase_gen.sv]
// Four-phase instruction cycle generator
`timescale 1ns/1ps
module mnr_phase_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Current phase
  output mnr_pkg::mnr_phase_t phase
);
  import mnr_pkg::*;

  // Walk Q1..Q4 once per enabled clock, Gray order so one bit flips per step
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= MNR_Q1;
    end else if (clk_en) begin
      unique case (phase)
        MNR_Q1: phase <= MNR_Q2;
        MNR_Q2: phase <= MNR_Q3;
        MNR_Q3: phase <= MNR_Q4;
        MNR_Q4: phase <= MNR_Q1;
      endcase
    end
  end

endmodule : mnr_phase_gen

// [verilog/mnr_pkg.sv]
// Shared constants, opcode patterns and carrier types for the instruction executor
package mnr_pkg;

  // Instruction, data and PC widths
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 16;

  // Hardware return stack geometry
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned STACK_PTR_W = 4;

  // Opcode patterns
  localparam logic [15:0] OPC_NOP = 16'h0000;
  localparam logic [15:0] OPC_RET_INT = 16'h0005;
  localparam logic [7:0] OPC_MUL_FILE_HI = 8'h34;
  localparam logic [6:0] OPC_NEG_W_HI = 7'h16;
  localparam logic [7:0] OPC_RET_LIT_HI = 8'hB6;

  // Field positions: negate select in the instruction word, disable bit in the status register
  localparam int unsigned NEG_SEL_BIT = 8;
  localparam int unsigned GLINT_BIT = 4;

  // Reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic GLINT_RST = 1'b1;
  localparam logic [15:0] IR_RST = 16'h0000;

  // Constant increments and the negate overflow byte
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [8:0] NEG_ONE9 = 9'h001;
  localparam logic [4:0] NEG_ONE5 = 5'h01;
  localparam logic [7:0] BYTE_MIN_NEG = 8'h80;

  // Four-phase instruction cycle, Gray coded
  typedef enum logic [1:0] {
    MNR_Q1 = 2'b00,
    MNR_Q2 = 2'b01,
    MNR_Q3 = 2'b11,
    MNR_Q4 = 2'b10
  } mnr_phase_t;

  // First cycle or the idle second cycle of a two-cycle instruction
  typedef enum logic {
    MNR_ST_RUN = 1'b0,
    MNR_ST_FLUSH = 1'b1
  } mnr_state_t;

  // Decoded operation classes
  typedef enum logic [2:0] {
    MNR_OP_NOP,
    MNR_OP_MUL,
    MNR_OP_NEG,
    MNR_OP_RET_INT,
    MNR_OP_RET_LIT,
    MNR_OP_OTHER
  } mnr_op_t;

  // Arithmetic status flags
  typedef struct packed {
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } mnr_flags_t;

  localparam mnr_flags_t FLAGS_RST = '{default: 1'b0};

  // Data file write port
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } mnr_file_wr_t;

  localparam mnr_file_wr_t FILE_WR_RST = '{default: 1'b0};

endpackage : mnr_pkg

// [verilog/mnr_ret_stack.sv]
// Sixteen-level hardware return stack
`timescale 1ns/1ps
module mnr_ret_stack (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Push and pop requests
  input wire logic push,
  input wire logic [15:0] push_addr,
  input wire logic pop,
  // Top entry and depth
  output logic [15:0] top_of_stack_entry,
  output logic [3:0] stack_ptr
);
  import mnr_pkg::*;

  logic [15:0] mem [STACK_DEPTH];
  logic [3:0] top_idx;

  // Pointer wraps like a circular stack; no overflow or underflow trap
  assign top_idx = stack_ptr - 4'h1;
  assign top_of_stack_entry = mem[top_idx];

  // Pointer moves; push wins if both arrive together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr <= 4'h0;
    end else if (clk_en) begin
      if (push) begin
        stack_ptr <= stack_ptr + 4'h1;
      end else if (pop) begin
        stack_ptr <= top_idx;
      end
    end
  end

  // Storage has no reset; entries are only read after being written
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[stack_ptr] <= push_addr;
    end
  end

endmodule : mnr_ret_stack
